// [logic/pioc_pkg.sv]
/*
  Shared constants and mode types for the programmable I/O cell.
  Assumes a single 40 MHz reference clock and a synchronous reset.
*/
package pioc_pkg;
  localparam int unsigned CLK_PERIOD_PS = 25_000;
  localparam int unsigned SYNC_STAGES   = 3;
  localparam int unsigned BUF_DEPTH     = 2;
  localparam logic        PULL_RESET    = 1'b1;
  localparam logic        OE_RESET      = 1'b0;
  localparam logic        DATA_RESET    = 1'b0;

  typedef enum logic [1:0] {
    PIOC_IN_DIRECT = 2'b00,
    PIOC_IN_REG    = 2'b01,
    PIOC_IN_DDR    = 2'b10
  } pioc_in_mode_t;

  typedef enum logic [1:0] {
    PIOC_OUT_DIRECT = 2'b00,
    PIOC_OUT_REG    = 2'b01,
    PIOC_OUT_DDR    = 2'b10
  } pioc_out_mode_t;

  typedef enum logic [1:0] {
    PIOC_ST_POR  = 2'b00,
    PIOC_ST_LOAD = 2'b01,
    PIOC_ST_USER = 2'b10
  } pioc_state_t;
endpackage : pioc_pkg

// [logic/pioc_cell.sv]
/*
  Programmable I/O cell: input, output and tri-state register blocks,
  bank freeze latch, power-up and configuration gating of the pad.
  Assumes the pad buffer resolves pad_o / pad_oe / pad_pullup_en and
  returns the pad level on pad_i; power-on reset and configuration
  done arrive asynchronously from outside.
*/
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - DDR input samples the pad on both clock edges into two streams.
// - DDR output captures one core bit on each clock edge.
// - the two output bits are muxed onto the pad at twice clock rate.
// - output data reaches the pad registered or directly.
// - asserted hold freezes each participating unregistered input.
// - the freeze is bank-wide while each cell opts in on its own.
// - registered inputs hold only through the clock enable.
// - before configuration the pad is undriven with pull-up on.
// - the pad stays undriven until configuration has finished.
// - an unused configured cell blocks its input and drops pull-up.
// - each cell selects weak pull-up or no termination.
// - core logic stays idle until power-on reset is released.
// - release of power-on reset starts the configuration load.
module pioc_cell
  import pioc_pkg::*;
#(
  parameter int unsigned DW = 1
) (
  input  wire  logic                 ref_clk,
  input  wire  logic                 sys_rst,
  input  wire  logic                 por_n_pin,
  input  wire  logic                 cfg_done_pin,
  input  wire  logic                 cell_used,
  input  wire  pioc_pkg::pioc_in_mode_t  in_mode,
  input  wire  pioc_pkg::pioc_out_mode_t out_mode,
  input  wire  logic                 oe_registered,
  input  wire  logic                 pullup_sel,
  input  wire  logic                 freeze_en,
  input  wire  logic                 bank_freeze,
  input  wire  logic                 clk_en,
  input  wire  logic                 core_oe,
  input  wire  logic [DW-1:0]        core_d0,
  input  wire  logic [DW-1:0]        core_d1,
  input  wire  logic                 core_valid,
  output logic                       core_ready,
  output logic [DW-1:0]              din0,
  output logic [DW-1:0]              din1,
  input  wire  logic [DW-1:0]        pad_i,
  output logic [DW-1:0]              pad_o,
  output logic                       pad_oe,
  output logic                       pad_pullup_en,
  output logic                       core_active,
  output logic                       cfg_load_start
);
  import pioc_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // synchronisers for power-on reset and configuration done
  logic [SYNC_STAGES-1:0] por_sync_r;
  logic [SYNC_STAGES-1:0] done_sync_r;
  logic                   por_ok_r;
  logic                   done_r;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      por_sync_r  <= '0;
      done_sync_r <= '0;
      por_ok_r    <= 1'b0;
      done_r      <= 1'b0;
    end else begin
      por_sync_r  <= {por_sync_r[SYNC_STAGES-2:0], por_n_pin};
      done_sync_r <= {done_sync_r[SYNC_STAGES-2:0], cfg_done_pin};
      // a change counts once the last two stages agree
      if (por_sync_r[1] == por_sync_r[2]) por_ok_r <= por_sync_r[2];
      if (done_sync_r[1] == done_sync_r[2]) done_r <= done_sync_r[2];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // power-up sequencer
  pioc_state_t state_r;
  pioc_state_t state_nxt;
  logic        user_mode;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      PIOC_ST_POR:  if (por_ok_r) state_nxt = PIOC_ST_LOAD;
      PIOC_ST_LOAD: if (!por_ok_r) state_nxt = PIOC_ST_POR;
                    else if (done_r) state_nxt = PIOC_ST_USER;
      PIOC_ST_USER: if (!por_ok_r) state_nxt = PIOC_ST_POR;
      default:      state_nxt = PIOC_ST_POR;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_r <= PIOC_ST_POR;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign user_mode      = (state_r == PIOC_ST_USER);
  assign core_active    = (state_r != PIOC_ST_POR);
  assign cfg_load_start = (state_r == PIOC_ST_POR) && por_ok_r;

  ////////////////////////////////////////////////////////////////////////
  // two-entry buffer in front of the output register
  logic [DW-1:0] buf_mem_r [BUF_DEPTH];
  logic          buf_wp_r;
  logic          buf_rp_r;
  logic [1:0]    buf_cnt_r;
  logic          buf_push;
  logic          buf_pop;
  logic          buf_valid;
  logic          out_regd;

  assign out_regd   = (out_mode != PIOC_OUT_DIRECT);
  assign core_ready = (buf_cnt_r != 2'(BUF_DEPTH)) && core_active;
  assign buf_valid  = (buf_cnt_r != 2'd0);
  assign buf_push   = core_valid && core_ready;
  assign buf_pop    = buf_valid && clk_en && out_regd;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      buf_wp_r  <= 1'b0;
      buf_rp_r  <= 1'b0;
      buf_cnt_r <= 2'd0;
    end else begin
      if (buf_push) begin
        buf_mem_r[buf_wp_r] <= core_d0;
        buf_wp_r            <= ~buf_wp_r;
      end
      if (buf_pop) buf_rp_r <= ~buf_rp_r;
      buf_cnt_r <= buf_cnt_r + 2'(buf_push) - 2'(buf_pop);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // output and tri-state registers
  logic [DW-1:0] out_q0_r;
  logic [DW-1:0] out_q1_r;
  logic          oe_q_r;
  logic          oe_eff;
  logic [DW-1:0] out_data;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      out_q0_r <= {DW{DATA_RESET}};
      oe_q_r   <= OE_RESET;
    end else begin
      if (buf_pop) begin
        out_q0_r <= buf_mem_r[buf_rp_r];
      end
      if (clk_en) oe_q_r <= core_oe;
    end
  end

  always_ff @(negedge ref_clk) begin
    if (sys_rst) begin
      out_q1_r <= {DW{DATA_RESET}};
    end else if (clk_en) begin
      out_q1_r <= core_d1;
    end
  end

  always_comb begin
    unique case (out_mode)
      PIOC_OUT_DIRECT: out_data = core_d0;
      PIOC_OUT_REG:    out_data = out_q0_r;
      PIOC_OUT_DDR:    out_data = ref_clk ? out_q0_r : out_q1_r;
      default:         out_data = core_d0;
    endcase
  end

  assign oe_eff        = oe_registered ? oe_q_r : core_oe;
  assign pad_oe        = user_mode && cell_used && oe_eff;
  assign pad_o         = pad_oe ? out_data : {DW{1'b0}};
  assign pad_pullup_en = user_mode ? (cell_used && pullup_sel)
                                   : PULL_RESET;

  ////////////////////////////////////////////////////////////////////////
  // input registers and freeze latch
  logic [DW-1:0] in_q0_r;
  logic [DW-1:0] in_q1_r;
  logic [DW-1:0] hold_r;
  logic          frozen;
  logic          in_open;

  assign frozen  = bank_freeze && freeze_en;
  assign in_open = user_mode && cell_used;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      in_q0_r <= {DW{DATA_RESET}};
      hold_r  <= {DW{DATA_RESET}};
    end else begin
      if (clk_en) in_q0_r <= pad_i;
      if (!frozen) hold_r <= pad_i;
    end
  end

  always_ff @(negedge ref_clk) begin
    if (sys_rst) begin
      in_q1_r <= {DW{DATA_RESET}};
    end else if (clk_en) begin
      in_q1_r <= pad_i;
    end
  end

  always_comb begin
    din0 = {DW{1'b0}};
    din1 = {DW{1'b0}};
    if (in_open) begin
      unique case (in_mode)
        PIOC_IN_DIRECT: din0 = frozen ? hold_r : pad_i;
        PIOC_IN_REG:    din0 = in_q0_r;
        PIOC_IN_DDR: begin
          din0 = in_q0_r;
          din1 = in_q1_r;
        end
        default:        din0 = pad_i;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  property p_float_pre_cfg;
    @(posedge ref_clk) disable iff (sys_rst)
      !user_mode |-> (!pad_oe && pad_pullup_en);
  endproperty
  a_float_pre_cfg: assert property (p_float_pre_cfg)
    else $error("pad driven or pull-up off before configuration");
  property p_user_after_done;
    @(posedge ref_clk) disable iff (sys_rst)
      $rose(user_mode) |-> $past(done_r) && $past(state_r == PIOC_ST_LOAD);
  endproperty
  a_user_after_done: assert property (p_user_after_done)
    else $error("user mode entered without finished configuration");
  property p_unused_blocked;
    @(posedge ref_clk) disable iff (sys_rst)
      (user_mode && !cell_used) |-> (din0 == '0 && !pad_pullup_en && !pad_oe);
  endproperty
  a_unused_blocked: assert property (p_unused_blocked)
    else $error("unused cell not blocked");
  property p_pull_sel;
    @(posedge ref_clk) disable iff (sys_rst)
      (user_mode && cell_used) |-> (pad_pullup_en == pullup_sel);
  endproperty
  a_pull_sel: assert property (p_pull_sel)
    else $error("pull-up does not follow selection");
  property p_core_idle;
    @(posedge ref_clk) disable iff (sys_rst)
      !por_ok_r |=> !core_active;
  endproperty
  a_core_idle: assert property (p_core_idle)
    else $error("core active while power-on reset held");
  property p_load_start;
    @(posedge ref_clk) disable iff (sys_rst)
      cfg_load_start |=> (state_r == PIOC_ST_LOAD) && !cfg_load_start;
  endproperty
  a_load_start: assert property (p_load_start)
    else $error("load start without entering load state");
  property p_oe_float;
    @(posedge ref_clk) disable iff (sys_rst)
      !oe_eff |-> !pad_oe;
  endproperty
  a_oe_float: assert property (p_oe_float)
    else $error("pad driven with output enable low");
  property p_freeze_hold;
    @(posedge ref_clk) disable iff (sys_rst)
      (frozen && in_open && in_mode == PIOC_IN_DIRECT) [*2] |->
        $stable(din0);
  endproperty
  a_freeze_hold: assert property (p_freeze_hold)
    else $error("frozen input changed");
  property p_ce_hold;
    @(posedge ref_clk) disable iff (sys_rst)
      !clk_en |=> $stable(in_q0_r) && $stable(out_q0_r) && $stable(oe_q_r);
  endproperty
  a_ce_hold: assert property (p_ce_hold)
    else $error("register changed with clock enable low");
  property p_reg_out;
    @(posedge ref_clk) disable iff (sys_rst)
      (buf_pop && out_mode == PIOC_OUT_REG) |=>
        out_q0_r == $past(buf_mem_r[buf_rp_r]);
  endproperty
  a_reg_out: assert property (p_reg_out)
    else $error("registered output missed buffered word");
endmodule : pioc_cell

`default_nettype wire

// [verification/pioc_core_model.sv]
/* core-side model: streams counting words into the cell's buffer.
   assumes a word is taken on valid and ready at a rising edge. */
`timescale 1ns/1ps
`default_nettype none
module pioc_core_model #(
  parameter int unsigned DW = 8
) (
  input  wire logic          ref_clk,
  input  wire logic          go,
  input  wire logic          core_ready,
  output logic               core_valid,
  output logic [DW-1:0]      core_d0,
  output logic               acc,
  output logic [DW-1:0]      acc_d
);
  int            seed  = 61503;
  logic [DW-1:0] cnt_r = DW'(1);
  logic          v;
  initial begin
    core_valid = 0;
    core_d0    = '0;
    acc        = 0;
    acc_d      = '0;
  end
  // word held until ready seen; idle data toggles so it is never stale
  always @(posedge ref_clk) begin
    acc   <= core_valid && core_ready;
    acc_d <= core_d0;
    if (core_valid && core_ready)
      cnt_r <= cnt_r + 1'b1;
    if (!core_valid || core_ready) begin
      v = go && ($random(seed) % 4 != 0);
      core_valid <= v;
      core_d0    <= v ? cnt_r + DW'(core_valid && core_ready) : ~core_d0;
    end
  end
endmodule : pioc_core_model
`default_nettype wire

// [verification/tb.sv]
/* top bench: drives the cell and the core model, checks pad and core side.
   assumes pioc_pkg, pioc_cell and pioc_core_model are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module tb;
  import pioc_pkg::*;
  localparam int unsigned DW = 8;
  logic ref_clk = 0, sys_rst = 1, por_n_pin = 0, cfg_done_pin = 0;
  logic cell_used = 1, oe_registered = 0, pullup_sel = 1, freeze_en = 1;
  logic bank_freeze = 0, clk_en = 1, core_oe = 1, go = 0, watch = 0;
  logic core_valid, core_ready, pad_oe, pad_pullup_en, core_active;
  logic cfg_load_start, acc;
  logic [DW-1:0] core_d0, core_d1 = '0, pad_i = '0, din0, din1, pad_o;
  logic [DW-1:0] acc_d, last_w = '0, a, b;
  logic [DW-1:0] exp_q[$];
  pioc_in_mode_t  in_mode  = PIOC_IN_DIRECT;
  pioc_out_mode_t out_mode = PIOC_OUT_REG;
  int errors = 0, checked = 0, seed = 61503, n;

  pioc_cell #(.DW(DW)) u_dut (.*);
  pioc_core_model #(.DW(DW)) u_core (.*);

  always #12.5 ref_clk = ~ref_clk;

  task automatic chk(string what, logic [DW-1:0] exp, logic [DW-1:0] got);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic at(int k);
    repeat (k) @(posedge ref_clk);
  endtask : at

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : report_and_stop

  ////////////////////////////////////////////////////////////////////
  // notes taken words; watcher pops one on every pad change
  always @(posedge ref_clk)
    if (acc && watch)
      exp_q.push_back(acc_d);
  always @(posedge ref_clk) begin
    #3;
    if (watch && pad_o !== last_w) begin
      chk("pad_o", exp_q.size() ? exp_q.pop_front() : ~pad_o, pad_o);
      last_w = pad_o;
    end
  end

  // whole run is some 190 cycles
  initial begin
    #100_000;
    errors++;
    report_and_stop();
  end

  ////////////////////////////////////////////////////////////////////
  initial begin
    at(6);
    sys_rst <= 0;
    at(1);
    #3;
    chk("pad_oe", 0, pad_oe);
    chk("pullup", 1, pad_pullup_en);
    chk("active", 0, core_active);
    chk("ready", 0, core_ready);
    at(1);
    por_n_pin <= 1;
    for (n = 0; n < 20 && cfg_load_start !== 1; n++) @(posedge ref_clk) #3;
    chk("load_start", 1, cfg_load_start);
    chk("active", 0, core_active);
    at(1);
    #3;
    chk("load_start", 0, cfg_load_start);
    chk("active", 1, core_active);
    at(4);
    #3;
    chk("pad_oe", 0, pad_oe);
    chk("pullup", 1, pad_pullup_en);
    at(1);
    cfg_done_pin <= 1;
    for (n = 0; n < 20 && pad_oe !== 1; n++) @(posedge ref_clk) #3;
    chk("pad_oe", 1, pad_oe);
    chk("pullup", 1, pad_pullup_en);
    at(1);
    pullup_sel <= 0;
    at(2);
    #3;
    chk("pullup", 0, pad_pullup_en);
    $display("test power_up done");
    last_w = pad_o;
    at(1);
    watch <= 1;
    go <= 1;
    at(60);
    clk_en <= 0;
    at(6);
    #3;
    chk("ready", 0, core_ready);
    at(1);
    clk_en <= 1;
    at(40);
    go <= 0;
    at(8);
    #3;
    chk("queue", 0, DW'(exp_q.size()));
    watch = 0;
    at(1);
    out_mode <= PIOC_OUT_DIRECT;
    #3;
    chk("pad_o", core_d0, pad_o);
    $display("test stream done");
    at(1);
    out_mode <= PIOC_OUT_REG;
    core_oe <= 0;
    #3;
    chk("pad_oe", 0, pad_oe);
    chk("pad_o", 0, pad_o);
    at(1);
    oe_registered <= 1;
    core_oe <= 1;
    #3;
    chk("pad_oe", 0, pad_oe);
    at(1);
    clk_en <= 0;
    core_oe <= 0;
    #3;
    chk("pad_oe", 1, pad_oe);
    at(2);
    #3;
    chk("pad_oe", 1, pad_oe);
    at(1);
    clk_en <= 1;
    at(1);
    #3;
    chk("pad_oe", 0, pad_oe);
    at(1);
    core_oe <= 1;
    oe_registered <= 0;
    out_mode <= PIOC_OUT_DDR;
    core_d1 <= 8'hA5;
    at(3);
    #3;
    chk("pad_o", last_w, pad_o);
    @(negedge ref_clk) #3;
    chk("pad_o", 8'hA5, pad_o);
    $display("test output_enable done");
    at(1);
    in_mode <= PIOC_IN_REG;
    bank_freeze <= 1;
    pad_i <= 8'h3C;
    at(1);
    #3;
    chk("din0", 8'h3C, din0);
    at(1);
    clk_en <= 0;
    pad_i <= 8'hC3;
    at(2);
    #3;
    chk("din0", 8'h3C, din0);
    at(1);
    clk_en <= 1;
    in_mode <= PIOC_IN_DIRECT;
    bank_freeze <= 0;
    #3;
    chk("din0", 8'hC3, din0);
    at(1);
    bank_freeze <= 1;
    at(1);
    pad_i <= 8'h0F;
    #3;
    chk("din0", 8'hC3, din0);
    at(1);
    freeze_en <= 0;
    #3;
    chk("din0", 8'h0F, din0);
    at(1);
    in_mode <= PIOC_IN_DDR;
    freeze_en <= 1;
    repeat (8) begin
      a = DW'($random(seed));
      b = DW'($random(seed));
      at(1);
      pad_i <= a;
      at(1);
      pad_i <= b;
      @(negedge ref_clk) #3;
      chk("din0", a, din0);
      chk("din1", b, din1);
    end
    $display("test inputs done");
    at(1);
    cell_used <= 0;
    pullup_sel <= 1;
    at(2);
    #3;
    chk("pullup", 0, pad_pullup_en);
    chk("din0", 0, din0);
    chk("pad_oe", 0, pad_oe);
    $display("test unused done");
    at(1);
    cell_used <= 1;
    por_n_pin <= 0;
    for (n = 0; n < 20 && core_active !== 0; n++) @(posedge ref_clk) #3;
    chk("active", 0, core_active);
    chk("pad_oe", 0, pad_oe);
    chk("pullup", 1, pad_pullup_en);
    $display("test power_loss done");
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
